// ---- htm_half_timer.v ----
// one 16-bit half of a general timer: one-shot, periodic, edge count, edge time, pwm
`timescale 1ns/10ps
// How it works
// RQ1 - one-shot and periodic count down 16 bits, with optional 8-bit prescaler
// RQ2 - mode field picks one-shot or periodic; prescale comes from prescale register
// RQ3 - enable starts countdown; after zero, reload load and prescale next cycle
// RQ4 - one-shot stops and clears enable at terminal count; periodic keeps counting
// RQ5 - reaching zero sets raw time-out flag until software clears it
// RQ6 - unmasked time-out sets masked flag and raises the interrupt
// RQ7 - adc trigger on time-out only when trigger enable bit set
// RQ8 - writing load while running makes counter adopt it next cycle
// RQ9 - stall bit freezes counter while debugger halts processor
// RQ10 - outside signal holds each new level two clocks at least
// RQ11 - prescaler bypassed in edge count, edge time and pwm modes
// RQ12 - capture mode bit zero selects edge count; event field picks edges
// RQ13 - software sets load minus match equal to wanted edge count
// RQ14 - each edge decrements by one; at match set raw and masked match flags
// RQ15 - after match reload, clear enable, ignore edges until re-enabled
// RQ16 - capture mode bit one: free-running edge timer, one edge kind only
// RQ17 - selected edge copies count to value register and sets capture flags
// RQ18 - edge timer keeps running, reloading from load at zero
// RQ19 - pwm needs alternate select one, capture bit zero, mode two
// RQ20 - pwm reloads after zero, runs until disabled, raises no flags
// RQ21 - pwm output rises at load value, falls at match value
// RQ22 - output level bit inverts the pwm output
// RQ23 - mode value one is one-shot, two is periodic
// RQ24 - halves run independently only when global config holds four
// RQ25 - both capture modes need mode field three
// RQ26 - prescaler advances counter every prescale plus one clocks
`include "htm_timer_regs.vh"

module htm_half_timer (
  // clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // register port
  input wire [`HTM_ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // system
  input wire i_dbg_halt,
  input wire i_ccp,
  // outputs
  output reg o_irq,
  output reg o_adc_trig,
  output reg o_pwm
);

  // decoded mode selection
  localparam ST_IDLE = 4'b0001;
  localparam ST_TIMER = 4'b0010;
  localparam ST_CAPT = 4'b0100;
  localparam ST_PWM = 4'b1000;

  // word map of the plain port, data in the low bits, upper bits read zero
  //   0 global config, 1 mode, 2 control, 3 interrupt mask
  //   4 raw status, 5 masked status, 6 flag clear, write ones to clear
  //   7 interval load, 8 match, 9 prescale, 10 timer value
  // mode word: [1:0] mode field, [2] capture mode bit, [3] alternate select
  // control word: [0] enable, [1] stall, [3:2] edge, [5] adc trigger, [6] invert
  // status, mask and clear share one order: time-out, match, capture event
  // software registers
  reg [2:0] global_config_reg_q;
  reg [3:0] half_timer_mode_reg_q;
  reg [6:0] control_reg_q;
  reg [2:0] interrupt_mask_reg_q;
  wire [2:0] raw_status_reg_q;
  reg [15:0] interval_load_reg_q;
  reg [15:0] match_reg_q;
  reg [7:0] prescale_reg_q;
  reg [15:0] timer_value_reg_q;
  // counting state
  reg [15:0] cnt_q;
  reg [7:0] pre_q;
  reg ccp_q;
  reg pwm_raw_q;

  // field views
  wire [1:0] timer_mode_field = half_timer_mode_reg_q[`HTM_MODE_TMR_LO+1:`HTM_MODE_TMR_LO];
  wire capture_mode_bit = half_timer_mode_reg_q[`HTM_MODE_CMR];
  wire alternate_mode_select = half_timer_mode_reg_q[`HTM_MODE_AMS];
  wire timer_enable_bit = control_reg_q[`HTM_CTL_EN];
  wire debug_stall_bit = control_reg_q[`HTM_CTL_STALL];
  wire [1:0] edge_select_field = control_reg_q[`HTM_CTL_EVT_LO+1:`HTM_CTL_EVT_LO];
  wire adc_trigger_enable = control_reg_q[`HTM_CTL_OTE];
  wire pwm_output_level = control_reg_q[`HTM_CTL_PWML];

  // mode decode, used by counter and flag logic
  function [3:0] htm_decode;
    input [2:0] cfg;
    input [1:0] tmr;
    input cmr;
    input ams;
    begin
      if (cfg != `HTM_CFG_SPLIT) begin // [RQ24]
        htm_decode = ST_IDLE;
      end else if (ams && !cmr && tmr == `HTM_TMR_PERIODIC) begin // [RQ19]
        htm_decode = ST_PWM;
      end else if (tmr == `HTM_TMR_CAPTURE) begin // [RQ25]
        htm_decode = ST_CAPT;
      end else if (tmr == `HTM_TMR_ONESHOT || tmr == `HTM_TMR_PERIODIC) begin // [RQ23]
        htm_decode = ST_TIMER;
      end else begin
        htm_decode = ST_IDLE;
      end
    end
  endfunction

  // decoded mode and register write strobes
  wire [3:0] mode = htm_decode(global_config_reg_q, timer_mode_field, capture_mode_bit,
                               alternate_mode_select);
  wire wr_ctl = i_wr && (i_addr == `HTM_OFF_CTL);
  wire wr_load = i_wr && (i_addr == `HTM_OFF_LOAD);
  wire wr_clr = i_wr && (i_addr == `HTM_OFF_CLR);

  // edge detection on the capture/compare pin; pin taken as synchronous [RQ10]
  // ccp_q idles low like the pin, so reset makes no false edge
  wire rise = i_ccp && !ccp_q;
  wire fall = !i_ccp && ccp_q;
  reg edge_hit;
  always @* begin
    case (edge_select_field)
      `HTM_EVT_RISE: edge_hit = rise; // [RQ12]
      `HTM_EVT_FALL: edge_hit = fall;
      `HTM_EVT_BOTH: edge_hit = (rise | fall) && !capture_mode_bit; // [RQ16]
      default: edge_hit = 1'b0;
    endcase
  end

  // prescaler tick only in one-shot/periodic; others bypass it
  // a prescale of zero ticks every clock, which keeps the plain 16-bit range
  wire pre_tick = (mode != ST_TIMER) || (pre_q == `HTM_PRE_RST); // [RQ11] [RQ26]
  wire halted = debug_stall_bit && i_dbg_halt; // [RQ9]
  wire run = timer_enable_bit && !halted && mode != ST_IDLE;
  wire at_zero = (cnt_q == `HTM_ZERO16);
  // time-out event: timer modes at zero on an advancing tick
  wire timeout = run && mode == ST_TIMER && at_zero && pre_tick; // [RQ3]
  // match event in edge count mode, checked once counter moved
  wire cnt_match = run && mode == ST_CAPT && !capture_mode_bit && cnt_q == match_reg_q;
  wire cap_evt = run && mode == ST_CAPT && capture_mode_bit && edge_hit; // [RQ17]

  // counter, prescaler and enable self-clear
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= `HTM_LOAD_RST;
      pre_q <= `HTM_PRE_RST;
      control_reg_q <= 7'h00;
      ccp_q <= 1'b0;
    end else begin
      ccp_q <= i_ccp;
      // software write comes first; hardware self-clear of enable wins
      if (wr_ctl) begin
        control_reg_q <= i_wdata[6:0];
      end
      // a load write wins over counting in every mode
      if (wr_load) begin
        cnt_q <= i_wdata[15:0]; // [RQ8]
        pre_q <= prescale_reg_q;
      end else if (run) begin
        if (mode == ST_TIMER) begin
          if (!pre_tick) begin
            pre_q <= pre_q - 8'h01; // [RQ1]
          end else if (at_zero) begin
            // zero lasts one tick, so a period is load plus one ticks
            cnt_q <= interval_load_reg_q; // [RQ3]
            pre_q <= prescale_reg_q;
            if (timer_mode_field == `HTM_TMR_ONESHOT) begin
              control_reg_q[`HTM_CTL_EN] <= 1'b0; // [RQ4]
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;
            pre_q <= prescale_reg_q;
          end
        end else if (mode == ST_CAPT && !capture_mode_bit) begin
          // edge count: the match is looked at before the next edge
          if (cnt_match) begin
            cnt_q <= interval_load_reg_q; // [RQ15]
            control_reg_q[`HTM_CTL_EN] <= 1'b0;
          end else if (edge_hit) begin
            cnt_q <= cnt_q - 16'h0001; // [RQ14]
          end
        end else if (at_zero) begin
          // edge time and pwm run free and reload the cycle after zero
          cnt_q <= interval_load_reg_q; // [RQ18] [RQ20]
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end

  // global configuration; anything but the split value keeps the half idle
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      global_config_reg_q <= 3'h0;
    end else if (i_wr && i_addr == `HTM_OFF_CFG) begin
      global_config_reg_q <= i_wdata[2:0];
    end
  end

  // mode word: mode field, capture mode bit, alternate select
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      half_timer_mode_reg_q <= 4'h0;
    end else if (i_wr && i_addr == `HTM_OFF_MODE) begin
      half_timer_mode_reg_q <= i_wdata[3:0]; // [RQ2]
    end
  end

  // interrupt mask, one bit per status flag
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      interrupt_mask_reg_q <= 3'h0;
    end else if (i_wr && i_addr == `HTM_OFF_MASK) begin
      interrupt_mask_reg_q <= i_wdata[2:0];
    end
  end

  // interval load; a running counter also takes it through the load strobe
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      interval_load_reg_q <= `HTM_LOAD_RST;
    end else if (wr_load) begin
      interval_load_reg_q <= i_wdata[15:0];
    end
  end

  // match value for edge count and pwm
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      match_reg_q <= `HTM_MATCH_RST;
    end else if (i_wr && i_addr == `HTM_OFF_MATCH) begin
      match_reg_q <= i_wdata[15:0]; // [RQ13]
    end
  end

  // prescale value, reloaded at every tick of the main counter
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale_reg_q <= `HTM_PRE_RST;
    end else if (i_wr && i_addr == `HTM_OFF_PRE) begin
      prescale_reg_q <= i_wdata[7:0]; // [RQ2]
    end
  end

  // sticky raw status, one flop per flag; a new event wins over a same-cycle clear
  wire [2:0] set_bits = {cap_evt, cnt_match, timeout}; // pwm raises none [RQ20]
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      // each flag keeps its set and clear local to its own bit
      reg flag_q;
      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          flag_q <= 1'b0;
        end else if (set_bits[gi]) begin
          flag_q <= 1'b1; // [RQ5] [RQ14] [RQ17]
        end else if (wr_clr && i_wdata[gi]) begin
          flag_q <= 1'b0;
        end
      end
      assign raw_status_reg_q[gi] = flag_q;
    end
  endgenerate

  // captured count held until next selected edge
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_value_reg_q <= `HTM_LOAD_RST;
    end else if (cap_evt) begin
      timer_value_reg_q <= cnt_q; // [RQ17]
    end
  end

  // interrupt line from the masked flags
  wire [2:0] masked = raw_status_reg_q & interrupt_mask_reg_q; // [RQ6]
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |masked; // [RQ6]
    end
  end

  // one-cycle adc pulse, only with its enable
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_adc_trig <= 1'b0;
    end else begin
      o_adc_trig <= timeout && adc_trigger_enable; // [RQ7]
    end
  end

  // raw pwm waveform; leaving pwm mode parks it low
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pwm_raw_q <= 1'b0;
    end else if (mode == ST_PWM && timer_enable_bit) begin
      if (cnt_q == interval_load_reg_q) begin
        pwm_raw_q <= 1'b1; // [RQ21]
      end else if (cnt_q == match_reg_q) begin
        pwm_raw_q <= 1'b0;
      end
    end else begin
      pwm_raw_q <= 1'b0;
    end
  end

  // pin stage; the extra flop keeps the pin glitch free at the cost of a cycle
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pwm <= 1'b0;
    end else begin
      o_pwm <= pwm_raw_q ^ pwm_output_level; // [RQ22]
    end
  end

  // read data one cycle after the strobe; unmapped reads as zero
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `HTM_OFF_CFG: o_rdata <= {29'h0, global_config_reg_q};
        `HTM_OFF_MODE: o_rdata <= {28'h0, half_timer_mode_reg_q};
        `HTM_OFF_CTL: o_rdata <= {25'h0, control_reg_q};
        `HTM_OFF_MASK: o_rdata <= {29'h0, interrupt_mask_reg_q};
        `HTM_OFF_RAW: o_rdata <= {29'h0, raw_status_reg_q};
        `HTM_OFF_MIS: o_rdata <= {29'h0, masked};
        `HTM_OFF_LOAD: o_rdata <= {16'h0, interval_load_reg_q};
        `HTM_OFF_MATCH: o_rdata <= {16'h0, match_reg_q};
        `HTM_OFF_PRE: o_rdata <= {24'h0, prescale_reg_q};
        // a set capture mode bit shows the capture, a clear one the live count
        `HTM_OFF_VALUE: o_rdata <= {16'h0, capture_mode_bit ? timer_value_reg_q : cnt_q};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule // htm_half_timer

// ---- htm_timer_regs.vh ----
// register offsets, field positions, encodings and reset values of the half timer
`ifndef HTM_TIMER_REGS_VH
`define HTM_TIMER_REGS_VH
// register offsets (word index on the plain port)
`define HTM_ADDR_W 4
`define HTM_OFF_CFG 4'h0
`define HTM_OFF_MODE 4'h1
`define HTM_OFF_CTL 4'h2
`define HTM_OFF_MASK 4'h3
`define HTM_OFF_RAW 4'h4
`define HTM_OFF_MIS 4'h5
`define HTM_OFF_CLR 4'h6
`define HTM_OFF_LOAD 4'h7
`define HTM_OFF_MATCH 4'h8
`define HTM_OFF_PRE 4'h9
`define HTM_OFF_VALUE 4'hA
// global configuration value that splits the timer into two halves
`define HTM_CFG_SPLIT 3'h4
// mode register fields
`define HTM_MODE_TMR_LO 0
`define HTM_MODE_CMR 2
`define HTM_MODE_AMS 3
`define HTM_TMR_ONESHOT 2'h1
`define HTM_TMR_PERIODIC 2'h2
`define HTM_TMR_CAPTURE 2'h3
// control register fields
`define HTM_CTL_EN 0
`define HTM_CTL_STALL 1
`define HTM_CTL_EVT_LO 2
`define HTM_CTL_OTE 5
`define HTM_CTL_PWML 6
// edge select encodings
`define HTM_EVT_RISE 2'h0
`define HTM_EVT_FALL 2'h1
`define HTM_EVT_BOTH 2'h3
// status, mask and clear bit positions
`define HTM_ST_TO 0
`define HTM_ST_MATCH 1
`define HTM_ST_CAP 2
// reset values
`define HTM_LOAD_RST 16'hFFFF
`define HTM_PRE_RST 8'h00
`define HTM_MATCH_RST 16'hFFFF
`define HTM_ZERO16 16'h0000
`endif

// ---- htm_chk.sv ----
// port checker for the half timer
`timescale 1ns/10ps
`include "htm_timer_regs.vh"
module htm_chk (
  // clock, reset, register port
  input wire i_core_clk,
  input wire i_rst,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  // pins
  input wire i_dbg_halt,
  input wire i_ccp,
  input wire o_irq,
  input wire o_adc_trig,
  input wire o_pwm
);
  reg [2:0] cfg_q;
  reg [2:0] mask_q;
  reg [3:0] mode_q;
  reg [1:0] ctl_q;
  reg [2:0] halt_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // shadow of written fields; ctl_q keeps trigger enable and stall only
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= 3'h0;
      mask_q <= 3'h0;
      mode_q <= 4'h0;
      ctl_q <= 2'h0;
      halt_q <= 3'h0;
    end else begin
      if (i_wr && i_addr == `HTM_OFF_CFG) cfg_q <= i_wdata[2:0];
      if (i_wr && i_addr == `HTM_OFF_MASK) mask_q <= i_wdata[2:0];
      if (i_wr && i_addr == `HTM_OFF_MODE) mode_q <= i_wdata[3:0];
      if (i_wr && i_addr == `HTM_OFF_CTL) ctl_q <= {i_wdata[5], i_wdata[1]};
      // saturating count of stalled cycles
      halt_q <= (ctl_q[0] && i_dbg_halt) ? halt_q + {2'h0, halt_q != 3'h7} : 3'h0;
    end
  end
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_rd_hi; $past(i_rd) |-> o_rdata[31:16] == 16'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("rdata upper bits");
  property p_cfg; $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata == {29'h0, $past(cfg_q)};
  endproperty
  a_cfg: assert property (p_cfg) else $error("config readback");
  property p_mode; $past(i_rd) && $past(i_addr) == 4'h1 |-> o_rdata == {28'h0, $past(mode_q)};
  endproperty
  a_mode: assert property (p_mode) else $error("mode readback");
  property p_ote; o_adc_trig |-> $past(ctl_q[1]) || $past(ctl_q[1], 2); endproperty
  a_ote: assert property (p_ote) else $error("trigger while disabled");
  property p_split; o_adc_trig |-> $past(cfg_q) == 3'h4 || $past(cfg_q, 2) == 3'h4; endproperty
  a_split: assert property (p_split) else $error("trigger unsplit");
  property p_pwm; $past(mode_q) == 4'hA && $past(mode_q, 2) == 4'hA |-> !o_adc_trig; endproperty
  a_pwm: assert property (p_pwm) else $error("trigger in pwm");
  property p_mask; $past(mask_q) == 3'h0 && $past(mask_q, 2) == 3'h0 |-> !o_irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_stall; halt_q >= 3'h4 |-> !o_adc_trig && $stable(o_pwm); endproperty
  a_stall: assert property (p_stall) else $error("moved while stalled");
endmodule // htm_chk
bind htm_half_timer htm_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_dbg_halt(i_dbg_halt), .i_ccp(i_ccp), .o_irq(o_irq), .o_adc_trig(o_adc_trig),
  .o_pwm(o_pwm));

// ---- htm_ccp_model.sv ----
// model of the outside signal on the capture/compare pin
`timescale 1ns/10ps
module htm_ccp_model (
  // clock
  input wire i_core_clk,
  // pin level toward the timer
  output logic o_ccp
);
  initial o_ccp = 1'b0;
  // three clocks per level, above the two-clock minimum
  task pulses(input int n);
    repeat (n) begin
      o_ccp <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      o_ccp <= 1'b0;
      repeat (3) @(posedge i_core_clk);
    end
  endtask
endmodule // htm_ccp_model

// ---- half_timer_16bit_modes_bench.sv ----
// self-checking bench for the half timer in its 16-bit modes
`timescale 1ns/10ps
`include "htm_timer_regs.vh"
module half_timer_16bit_modes_bench;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_dbg_halt = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, l, p;
  wire [31:0] o_rdata;
  wire i_ccp, o_irq, o_adc_trig, o_pwm;
  logic [31:0] rd_q[$], per_q[$];
  int fails = 0, checked = 0, cyc = 0, last = 0, ntrig = 0, k, hi;
  logic rd_d = 1'b0;
  logic [3:0] ra[7] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'h2, 4'hF, 4'h4};
  logic [31:0] rv[7] = '{32'hFFFF, 32'hFFFF, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
  logic [31:0] ev[3] = '{32'h0, 32'h4, 32'hC};
  int np[3] = '{4, 4, 2};
  always #50 i_core_clk = ~i_core_clk;
  htm_half_timer DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dbg_halt(i_dbg_halt),
    .i_ccp(i_ccp), .o_irq(o_irq), .o_adc_trig(o_adc_trig), .o_pwm(o_pwm));
  htm_ccp_model PART (.i_core_clk(i_core_clk), .o_ccp(i_ccp));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one bus cycle; a read notes its expected data
  task bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= w ? d : 32'h0;
    if (r) rd_q.push_back(d);
    @(posedge i_core_clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] d);
    bus(1'b0, 1'b1, a, d);
  endtask
  task idle(input int n);
    repeat (n) bus(1'b0, 1'b0, i_addr, 32'h0);
  endtask
  // extra edge after the pulse keeps queue pushes off the monitor's edge
  task wait_trig;
    idle(1);
    while (o_adc_trig !== 1'b1) idle(1);
    idle(1);
  endtask
  // monitor: read data, trigger spacing and the hang limit
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    rd_d <= i_rd;
    if (rd_d) check(o_rdata, rd_q.pop_front());
    if (o_adc_trig === 1'b1) begin
      ntrig++;
      if (per_q.size() > 0) check(32'(cyc - last), per_q.pop_front());
      last <= cyc;
    end
    if (cyc > 20000) begin
      fails++;
      results;
    end
  end
  initial begin
    void'($urandom(57));
    repeat (20) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // reset values; status is read-only, 0xF unmapped
    wr(`HTM_OFF_RAW, 32'h7);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(`HTM_OFF_CFG, 32'h4);
    wr(`HTM_OFF_MASK, 32'h7);
    rd(`HTM_OFF_CFG, 32'h4);
    repeat (4) begin
      l = $urandom_range(15, 1);
      p = $urandom_range(3, 0);
      wr(`HTM_OFF_MODE, 32'h2);
      wr(`HTM_OFF_PRE, p);
      wr(`HTM_OFF_LOAD, l);
      wr(`HTM_OFF_CTL, 32'h21);
      wait_trig;
      repeat (2) per_q.push_back((l + 1) * (p + 1));
      wait_trig;
      wait_trig;
      check(o_irq, 32'h1);
      wr(`HTM_OFF_CTL, 32'h0);
      rd(`HTM_OFF_MIS, 32'h1);
      wr(`HTM_OFF_CLR, 32'h7);
      rd(`HTM_OFF_RAW, 32'h0);
    end
    // load rewritten in mid-count
    wr(`HTM_OFF_PRE, 32'h0);
    wr(`HTM_OFF_LOAD, 32'hC8);
    wr(`HTM_OFF_CTL, 32'h21);
    idle(9);
    wr(`HTM_OFF_LOAD, 32'h4);
    rd(`HTM_OFF_VALUE, 32'h4);
    wait_trig;
    per_q.push_back(32'h5);
    wait_trig;
    // no trigger without its enable, none while stalled
    k = ntrig;
    wr(`HTM_OFF_CTL, 32'h01);
    idle(30);
    check(ntrig, k);
    rd(`HTM_OFF_RAW, 32'h1);
    i_dbg_halt <= 1'b1;
    wr(`HTM_OFF_CTL, 32'h23);
    idle(30);
    check(ntrig, k);
    i_dbg_halt <= 1'b0;
    wait_trig;
    // one-shot stops itself
    wr(`HTM_OFF_CTL, 32'h0);
    wr(`HTM_OFF_MODE, 32'h1);
    wr(`HTM_OFF_LOAD, 32'h6);
    rd(`HTM_OFF_MODE, 32'h1);
    wr(`HTM_OFF_CTL, 32'h21);
    wait_trig;
    k = ntrig;
    idle(40);
    check(ntrig, k);
    rd(`HTM_OFF_CTL, 32'h20);
    rd(`HTM_OFF_VALUE, 32'h6);
    // edge count per edge kind, surplus edges ignored
    wr(`HTM_OFF_MODE, 32'h3);
    wr(`HTM_OFF_LOAD, 32'hA);
    wr(`HTM_OFF_MATCH, 32'h6);
    foreach (ev[i]) begin
      wr(`HTM_OFF_CLR, 32'h7);
      wr(`HTM_OFF_CTL, ev[i] | 32'h1);
      idle(1);
      PART.pulses(np[i] + 2);
      rd(`HTM_OFF_RAW, 32'h2);
      rd(`HTM_OFF_CTL, ev[i]);
      rd(`HTM_OFF_VALUE, 32'hA);
    end
    // edge time capture on rising edges; second rise lands at count 0xFFF8
    wr(`HTM_OFF_MODE, 32'h7);
    wr(`HTM_OFF_LOAD, 32'hFFFF);
    wr(`HTM_OFF_CLR, 32'h7);
    wr(`HTM_OFF_CTL, 32'h1);
    idle(1);
    PART.pulses(2);
    rd(`HTM_OFF_MIS, 32'h4);
    rd(`HTM_OFF_VALUE, 32'hFFF8);
    // pwm duty over ten periods, plain then inverted
    wr(`HTM_OFF_CTL, 32'h0);
    wr(`HTM_OFF_MODE, 32'hA);
    wr(`HTM_OFF_LOAD, 32'h9);
    wr(`HTM_OFF_MATCH, 32'h3);
    wr(`HTM_OFF_CLR, 32'h7);
    for (k = 0; k < 2; k++) begin
      wr(`HTM_OFF_CTL, k ? 32'h41 : 32'h01);
      idle(20);
      hi = 0;
      repeat (100) begin
        @(posedge i_core_clk);
        hi += (o_pwm === 1'b1);
      end
      check(hi, k ? 32'h28 : 32'h3C);
    end
    rd(`HTM_OFF_RAW, 32'h0);
    idle(2);
    results;
  end
endmodule // half_timer_16bit_modes_bench
